// ===== src/pls_core.sv
// pid regulator with output limits, filters, run phases and sleep control
// What this block does
// - polarity is setting xor toggle input
// - clamp regulator result between programmable upper, lower bounds
// - second gain set only by input when enabled
// - zero integral time disables integral action
// - stopping clears output unless running while stopped
// - hold initial value for hold time at start
// - stop-operation setting gates reset and hold
// - feedback and output each low-pass filtered
// - units digit picks sleep trigger source
// - tens digit picks wake trigger source
// - positive direction: high sleeps, low wakes
// - reverse direction: low sleeps, high wakes
// - wake condition blocks entering sleep
// - frequency mode: low sleeps, high wakes
`timescale 1ns/10ps
module pls_core import pls_pkg::*; #(
	parameter int TICK_MS = PLS_TICK_TIME_MS
) (
	// clock, reset, enable
	input  wire logic               core_clk,
	input  wire logic               rstn,
	input  wire logic               ce,
	// drive control tick and run state
	input  wire logic               tick,
	input  wire logic               run,
	// digital input pins, asynchronous
	input  wire logic               di_pol_toggle,
	input  wire logic               di_gain_sel,
	// process samples
	input  wire pls_in_t            samples,
	// register port
	input  wire logic [PLS_AW-1:0]  reg_addr,
	input  wire logic [PLS_DW-1:0]  reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [PLS_DW-1:0]  reg_rdata,
	// results
	output logic signed [15:0]      pid_out,
	output logic                    sleep_active
);
	if (TICK_MS < 1) begin : g_chk
		$error("pls_core: TICK_MS must be at least one");
	end

	logic [PLS_DW-1:0]  regs [PLS_NREG];  // writable parameters
	logic [1:0]         pol_sync;         // polarity toggle synchroniser
	logic [1:0]         gsel_sync;        // gain select synchroniser
	logic [2:0]         tick_q;           // tick pipeline stages
	pls_phase_t         phase;            // run phase
	logic [31:0]        hold_ms;          // time spent in hold
	logic signed [47:0] integ_acc;        // integral accumulator
	logic signed [16:0] err_prev;         // last error for derivative
	logic signed [15:0] pid_raw;          // clamped regulator result
	logic signed [15:0] fb_filt;          // filtered feedback
	logic signed [15:0] out_filt;         // filtered output
	logic               clamped;          // result hit a bound
	logic               pol_neg;          // effective polarity negative
	logic               gain_two;         // second gain set in use
	logic               rws;              // keep computing while stopped
	logic [15:0]        kp;
	logic [15:0]        ti;
	logic [15:0]        td;
	logic signed [16:0] err;
	logic signed [47:0] next_acc;
	logic signed [15:0] next_raw;
	logic               next_clamped;
	logic               active;           // closed loop is regulating
	logic               sleep_cond;
	logic               wake_cond;
	logic [15:0]        slp_cfg;

	// pick the pressure feedback named by an analogue trigger code
	function automatic logic signed [15:0] press_sel(input logic use_two);
		press_sel = use_two ? samples.ain2 : samples.ain1;
	endfunction

	// limit a wide signed value to signed 16-bit bounds
	function automatic logic signed [15:0] clamp16(
		input logic signed [63:0] v,
		input logic signed [15:0] hi,
		input logic signed [15:0] lo
	);
		if (v > 64'(hi)) begin
			clamp16 = hi;
		end else if (v < 64'(lo)) begin
			clamp16 = lo;
		end else begin
			clamp16 = v[15:0];
		end
	endfunction

	// the pins are asynchronous: two flops before anything looks at them
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pol_sync  <= '0;
			gsel_sync <= '0;
		end else if (ce) begin
			pol_sync  <= {pol_sync[0], di_pol_toggle};
			gsel_sync <= {gsel_sync[0], di_gain_sel};
		end
	end

	assign rws      = regs[PLS_R_CTRL][PLS_B_RWS];
	assign slp_cfg  = regs[PLS_R_SLPCFG];
	assign pol_neg  = regs[PLS_R_CTRL][PLS_B_POL] ^ pol_sync[1];
	assign gain_two = regs[PLS_R_CTRL][PLS_B_GSW] & gsel_sync[1];
	assign kp = gain_two ? regs[PLS_R_KP2] : regs[PLS_R_KP1];
	assign ti = gain_two ? regs[PLS_R_TI2] : regs[PLS_R_TI1];
	assign td = gain_two ? regs[PLS_R_TD2] : regs[PLS_R_TD1];
	assign active = (phase == PLS_RUN);

	// register writes; status and output words are read only
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			for (int i = 0; i < PLS_NREG; i++) begin
				regs[i] <= PLS_RST[i];
			end
		end else if (ce) begin
			if (reg_wr && reg_addr < PLS_R_STAT) begin
				regs[reg_addr] <= reg_wdata;
			end
		end
	end

	// read data stands in the cycle after the strobe only
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			reg_rdata <= '0;
		end else if (ce) begin
			if (!reg_rd) begin
				reg_rdata <= '0;
			end else if (reg_addr < PLS_R_STAT) begin
				reg_rdata <= regs[reg_addr];
			end else if (reg_addr == PLS_R_STAT) begin
				reg_rdata <= pls_stat_t'{zero: '0, gain_two: gain_two,
					pol_neg: pol_neg, phase: phase,
					sleeping: sleep_active};
			end else if (reg_addr == PLS_R_OUT) begin
				reg_rdata <= pid_out;
			end else begin
				reg_rdata <= '0;  // unmapped reads as zero
			end
		end
	end

	// tick pipeline: feedback filter, regulator, output filter, output
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			tick_q <= '0;
		end else if (ce) begin
			tick_q <= {tick_q[1:0], tick};
		end
	end

	// feedback filter steps on the tick itself
	pls_lpf #(.W(16), .TICK_MS(TICK_MS)) u_fb_lpf (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.step     (tick),
		.load     (1'b0),
		.load_val ('0),
		.x        (samples.feedback),
		.tau_ms   (regs[PLS_R_FBTAU]),
		.y        (fb_filt)
	);

	// run phases; with run_while_stopped set the loop never leaves run
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			phase <= PLS_STOP;
		end else if (ce) begin
			if (rws) begin
				phase <= PLS_RUN;
			end else begin
				unique case (phase)
					PLS_STOP: begin
						if (run && regs[PLS_R_HOLD] != '0) begin
							phase <= PLS_HOLD;
						end else if (run) begin
							phase <= PLS_RUN;
						end
					end
					PLS_HOLD: begin
						if (!run) begin
							phase <= PLS_STOP;
						end else if (tick && hold_ms >=
							32'(regs[PLS_R_HOLD]) * 32'(PLS_HOLD_UNIT_MS)) begin
							phase <= PLS_RUN;
						end
					end
					PLS_RUN: begin
						if (!run) begin
							phase <= PLS_STOP;
						end
					end
				endcase
			end
		end
	end

	// hold timer counts elapsed time in milliseconds while holding
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			hold_ms <= '0;
		end else if (ce) begin
			if (phase != PLS_HOLD) begin
				hold_ms <= '0;
			end else if (tick) begin
				hold_ms <= hold_ms + 32'(TICK_MS);
			end
		end
	end

	// regulator arithmetic; polarity turns the error round
	always_comb begin
		logic signed [63:0] p_term;
		logic signed [63:0] i_term;
		logic signed [63:0] d_term;
		logic signed [63:0] sum;
		p_term = '0;
		i_term = '0;
		d_term = '0;
		sum    = '0;
		err = pol_neg ? 17'(fb_filt) - 17'(samples.setpoint)
			: 17'(samples.setpoint) - 17'(fb_filt);
		p_term = 64'(err) * $signed(64'(kp)) / 64'(PLS_GAIN_DIV);
		// integral halts while saturated to keep windup out
		next_acc = integ_acc;
		if (ti == '0) begin
			next_acc = '0;
		end else if (!clamped) begin
			next_acc = integ_acc + 48'(64'(err) * $signed(64'(kp))
				* 64'(TICK_MS));
		end
		if (ti != '0) begin
			i_term = 64'(next_acc) / ($signed(64'(ti))
				* 64'(PLS_TI_UNIT_MS)
				* 64'(PLS_GAIN_DIV));
		end
		d_term = (64'(err) - 64'(err_prev)) * $signed(64'(kp))
			* $signed(64'(td))
			/ (64'(TICK_MS) * 64'(PLS_GAIN_DIV));
		sum = p_term + i_term + d_term;
		next_raw = clamp16(sum, regs[PLS_R_UPPER],
			regs[PLS_R_LOWER]);
		next_clamped = (sum > 64'(signed'(regs[PLS_R_UPPER])))
			|| (sum < 64'(signed'(regs[PLS_R_LOWER])));
	end

	// regulator state, one update per tick after feedback is filtered
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			integ_acc <= '0;
			err_prev  <= '0;
			pid_raw   <= '0;
			clamped   <= 1'b0;
		end else if (ce) begin
			if (!active) begin
				// stopped or holding: no integration carried across
				integ_acc <= '0;
				err_prev  <= '0;
				clamped   <= 1'b0;
				pid_raw   <= (phase == PLS_HOLD)
					? regs[PLS_R_INIT] : '0;
			end else if (tick_q[0]) begin
				integ_acc <= next_acc;
				err_prev  <= err;
				pid_raw   <= next_raw;
				clamped   <= next_clamped;
			end
		end
	end

	// output filter; loaded directly outside closed-loop regulation
	pls_lpf #(.W(16), .TICK_MS(TICK_MS)) u_out_lpf (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.step     (tick_q[1]),
		.load     (!active),
		.load_val (pid_raw),
		.x        (pid_raw),
		.tau_ms   (regs[PLS_R_OUTTAU]),
		.y        (out_filt)
	);

	// in run the output moves only once polarity, clamp and filter are done; stop and hold set it directly
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pid_out <= '0;
		end else if (ce) begin
			if (phase == PLS_STOP) begin
				pid_out <= '0;
			end else if (phase == PLS_HOLD) begin
				pid_out <= regs[PLS_R_INIT];
			end else if (tick_q[2]) begin
				pid_out <= out_filt;
			end
		end
	end

	// sleep and wake conditions from the configured triggers
	always_comb begin
		logic signed [15:0] sp;
		logic signed [15:0] wp;
		logic               rev;
		rev = slp_cfg[PLS_F_DIR];
		sp  = press_sel(slp_cfg[PLS_F_SMODE +: 4] == PLS_SLP_AIN2);
		wp  = press_sel(slp_cfg[PLS_F_WMODE +: 4] == PLS_WAK_AIN2);
		unique case (slp_cfg[PLS_F_SMODE +: 4])
			PLS_SLP_FREQ: sleep_cond =
				samples.out_freq < regs[PLS_R_SLPF];
			PLS_SLP_AIN1, PLS_SLP_AIN2: sleep_cond = rev
				? sp < signed'(regs[PLS_R_SLPP])
				: sp > signed'(regs[PLS_R_SLPP]);
			default: sleep_cond = 1'b0;  // off or unused code
		endcase
		unique case (slp_cfg[PLS_F_WMODE +: 4])
			PLS_WAK_FREQ: wake_cond =
				samples.out_freq > regs[PLS_R_WAKF];
			PLS_WAK_AIN1, PLS_WAK_AIN2: wake_cond = rev
				? wp > signed'(regs[PLS_R_WAKP])
				: wp < signed'(regs[PLS_R_WAKP]);
			default: wake_cond = 1'b0;  // unused code never wakes
		endcase
	end

	// sleep decision once per tick; a true wake condition vetoes sleep
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sleep_active <= 1'b0;
		end else if (ce) begin
			if (slp_cfg[PLS_F_SMODE +: 4] == PLS_SLP_OFF) begin
				sleep_active <= 1'b0;
			end else if (tick && !sleep_active) begin
				sleep_active <= run && sleep_cond && !wake_cond;
			end else if (tick && wake_cond) begin
				sleep_active <= 1'b0;
			end
		end
	end
endmodule

// ===== src/pls_pkg.sv
// package: constants and carriers of the pid regulator and sleep supervisor
package pls_pkg;
	// register port geometry
	localparam int PLS_DW   = 16;
	localparam int PLS_AW   = 5;
	localparam int PLS_NREG = 20;
	// register indices
	localparam logic [4:0] PLS_R_CTRL   = 5'h00;
	localparam logic [4:0] PLS_R_UPPER  = 5'h01;
	localparam logic [4:0] PLS_R_LOWER  = 5'h02;
	localparam logic [4:0] PLS_R_KP1    = 5'h03;
	localparam logic [4:0] PLS_R_TI1    = 5'h04;
	localparam logic [4:0] PLS_R_TD1    = 5'h05;
	localparam logic [4:0] PLS_R_KP2    = 5'h06;
	localparam logic [4:0] PLS_R_TI2    = 5'h07;
	localparam logic [4:0] PLS_R_TD2    = 5'h08;
	localparam logic [4:0] PLS_R_FBTAU  = 5'h09;
	localparam logic [4:0] PLS_R_OUTTAU = 5'h0A;
	localparam logic [4:0] PLS_R_HOLD   = 5'h0B;
	localparam logic [4:0] PLS_R_INIT   = 5'h0C;
	localparam logic [4:0] PLS_R_SLPCFG = 5'h0D;
	localparam logic [4:0] PLS_R_SLPP   = 5'h0E;
	localparam logic [4:0] PLS_R_WAKP   = 5'h0F;
	localparam logic [4:0] PLS_R_SLPF   = 5'h10;
	localparam logic [4:0] PLS_R_WAKF   = 5'h11;
	localparam logic [4:0] PLS_R_STAT   = 5'h12;
	localparam logic [4:0] PLS_R_OUT    = 5'h13;
	// control register bits
	localparam int PLS_B_POL = 0;
	localparam int PLS_B_GSW = 1;
	localparam int PLS_B_RWS = 2;
	// sleep configuration digit fields, one nibble each
	localparam int PLS_F_SMODE = 0;
	localparam int PLS_F_WMODE = 4;
	localparam int PLS_F_DIR   = 8;
	// sleep and wake trigger codes
	localparam logic [3:0] PLS_SLP_OFF  = 4'h0;
	localparam logic [3:0] PLS_SLP_FREQ = 4'h1;
	localparam logic [3:0] PLS_SLP_AIN1 = 4'h2;
	localparam logic [3:0] PLS_SLP_AIN2 = 4'h3;
	localparam logic [3:0] PLS_WAK_FREQ = 4'h0;
	localparam logic [3:0] PLS_WAK_AIN1 = 4'h1;
	localparam logic [3:0] PLS_WAK_AIN2 = 4'h2;
	// scaling: percent in 0.1 % steps, integral time in 10 ms steps
	localparam int PLS_FULL_SCALE = 1000;
	localparam int PLS_GAIN_DIV   = 1000;
	localparam int PLS_TI_UNIT_MS = 10;
	localparam int PLS_TI_MAX     = 2000;
	localparam int PLS_TAU_MAX_MS = 30000;
	localparam int PLS_HOLD_UNIT_MS = 10;
	localparam int PLS_TICK_TIME_MS = 1;
	// reset values, by register index
	localparam logic [15:0] PLS_RST [PLS_NREG] = '{
		16'h0000, 16'h03E8, 16'h0000, 16'h0032, 16'h0064,
		16'h0000, 16'h0032, 16'h0064, 16'h0000, 16'h000A,
		16'h000A, 16'h0000, 16'h0000, 16'h0010, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
	// process samples from the drive, same clock domain
	typedef struct packed {
		logic signed [15:0] setpoint;
		logic signed [15:0] feedback;
		logic        [15:0] out_freq;
		logic signed [15:0] ain1;
		logic signed [15:0] ain2;
	} pls_in_t;
	// run phases of the regulator
	typedef enum logic [1:0] {PLS_STOP, PLS_HOLD, PLS_RUN} pls_phase_t;
	// status word layout
	typedef struct packed {
		logic [10:0] zero;
		logic        gain_two;
		logic        pol_neg;
		logic [1:0]  phase;
		logic        sleeping;
	} pls_stat_t;
endpackage

// ===== src/pls_lpf.sv
// first-order low-pass filter stepped once per control tick
`timescale 1ns/10ps
module pls_lpf import pls_pkg::*; #(
	parameter int W       = 16,
	parameter int TICK_MS = PLS_TICK_TIME_MS
) (
	// clock and reset
	input  wire logic                core_clk,
	input  wire logic                rstn,
	input  wire logic                ce,
	// control
	input  wire logic                step,
	input  wire logic                load,
	input  wire logic signed [W-1:0] load_val,
	// data
	input  wire logic signed [W-1:0] x,
	input  wire logic        [15:0]  tau_ms,
	output logic signed      [W-1:0] y
);
	logic signed [W+1:0]  diff;    // input minus state
	logic signed [W+33:0] scaled;  // diff times tick over tau plus tick
	logic signed [W-1:0]  next_y;

	// y += (x - y) * T / (tau + T); tau of zero passes straight through
	always_comb begin
		diff   = (W+2)'(x) - (W+2)'(y);
		// divisor kept signed: an unsigned tau would wrap a falling step
		scaled = ((W+34)'(diff) * (W+34)'(TICK_MS))
			/ $signed((W+34)'(tau_ms) + (W+34)'(TICK_MS));
		next_y = y + W'(scaled);
	end

	// load wins over step so a clear is never smeared by the filter
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			y <= '0;
		end else if (ce) begin
			if (load) begin
				y <= load_val;
			end else if (step) begin
				y <= next_y;
			end
		end
	end
endmodule

// ===== tb/pls_core_checker.sv
// checker: port-level assertions of the pid regulator and sleep supervisor
`timescale 1ns/10ps
module pls_core_checker import pls_pkg::*; (
	// clock, reset, enable
	input wire logic               core_clk,
	input wire logic               rstn,
	input wire logic               ce,
	// drive side
	input wire logic               tick,
	input wire logic               run,
	input wire logic               di_pol_toggle,
	input wire logic               di_gain_sel,
	input wire pls_in_t            samples,
	// register port
	input wire logic [PLS_AW-1:0]  reg_addr,
	input wire logic [PLS_DW-1:0]  reg_wdata,
	input wire logic               reg_wr,
	input wire logic               reg_rd,
	input wire logic [PLS_DW-1:0]  reg_rdata,
	// results
	input wire logic signed [15:0] pid_out,
	input wire logic               sleep_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic [15:0] sh [PLS_NREG]; // shadow of accepted writes
	logic [2:0]  di_age;        // edges since a pin input moved
	logic [2:0]  run_age;       // edges since run moved or a write
	logic [1:0]  di_p;          // last pin values
	logic        run_p;         // last run value
	// shadow follows writes below the read-only status index
	always_ff @(posedge core_clk) begin
		if (!rstn)
			sh <= PLS_RST;
		else if (ce && reg_wr && reg_addr < PLS_R_STAT)
			sh[reg_addr] <= reg_wdata;
	end
	// ages saturate at 7, past the synchroniser and tick pipe depth
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			di_p <= 2'h0;
			run_p <= 1'b0;
			di_age <= 3'h0;
			run_age <= 3'h0;
		end else begin
			di_p <= {di_pol_toggle, di_gain_sel};
			run_p <= run;
			if (di_p != {di_pol_toggle, di_gain_sel})
				di_age <= 3'h0;
			else if (di_age != 3'h7)
				di_age <= di_age + 3'h1;
			if (run_p != run || reg_wr)
				run_age <= 3'h0;
			else if (run_age != 3'h7)
				run_age <= run_age + 3'h1;
		end
	end
	property p_pol;
		reg_rd && reg_addr == PLS_R_STAT && di_age == 3'h7 |=> reg_rdata[3]
		== (sh[PLS_R_CTRL][PLS_B_POL] ^ $past(di_pol_toggle));
	endproperty
	a_pol: assert property (p_pol) else $error("bad polarity");
	property p_gain;
		reg_rd && reg_addr == PLS_R_STAT && di_age == 3'h7 |=> reg_rdata[4]
		== (sh[PLS_R_CTRL][PLS_B_GSW] & $past(di_gain_sel));
	endproperty
	a_gain: assert property (p_gain) else $error("bad gain set");
	property p_rws;
		reg_rd && reg_addr == PLS_R_STAT && run_age == 3'h7 &&
		sh[PLS_R_CTRL][PLS_B_RWS] |=> reg_rdata[2:1] == 2'h2;
	endproperty
	a_rws: assert property (p_rws) else $error("not running");
	property p_stop;
		(!run && !sh[PLS_R_CTRL][PLS_B_RWS])[*3] |-> pid_out == 16'sh0;
	endproperty
	a_stop: assert property (p_stop) else $error("not cleared");
	property p_hold;
		$rose(run) && !sh[PLS_R_CTRL][PLS_B_RWS] && sh[PLS_R_HOLD] != 0
		|-> ##2 pid_out == sh[PLS_R_INIT];
	endproperty
	a_hold: assert property (p_hold) else $error("no hold");
	property p_clamp;
		$changed(pid_out) && run && $past(run) && sh[PLS_R_HOLD] == 0 &&
		sh[PLS_R_OUTTAU] == 0 |-> pid_out <= $signed(sh[PLS_R_UPPER]) &&
		pid_out >= $signed(sh[PLS_R_LOWER]);
	endproperty
	a_clamp: assert property (p_clamp) else $error("out of bounds");
	property p_tick;
		$changed(pid_out) && run_age == 3'h7 |-> $past(tick, 4);
	endproperty
	a_tick: assert property (p_tick) else $error("untimed change");
	property p_off;
		sh[PLS_R_SLPCFG][3:0] == PLS_SLP_OFF |=> !sleep_active;
	endproperty
	a_off: assert property (p_off) else $error("sleep when off");
	property p_enter;
		$rose(sleep_active) |-> $past(tick) && $past(run);
	endproperty
	a_enter: assert property (p_enter) else $error("bad entry");
	property p_wake;
		$fell(sleep_active) |->
		$past(tick) || $past(sh[PLS_R_SLPCFG][3:0]) == PLS_SLP_OFF;
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake");
	c_sleep: cover property ($rose(sleep_active));
	c_wake: cover property ($fell(sleep_active));
	c_hold: cover property ($rose(run) && sh[PLS_R_HOLD] != 0);
endmodule
bind pls_core pls_core_checker u_chk (.core_clk(core_clk), .rstn(rstn),
	.ce(ce), .tick(tick), .run(run), .di_pol_toggle(di_pol_toggle),
	.di_gain_sel(di_gain_sel), .samples(samples), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pid_out(pid_out), .sleep_active(sleep_active));

// ===== tb/pls_core_tb.sv
// testbench: self-checking run of the pid regulator and sleep supervisor
`timescale 1ns/10ps
module pls_core_tb import pls_pkg::*; ;
	logic               core_clk = 1'b0; // 250 MHz
	logic               rstn, ce, tick, run;
	logic               di_pol_toggle, di_gain_sel;
	pls_in_t            samples;
	logic [PLS_AW-1:0]  reg_addr;
	logic [PLS_DW-1:0]  reg_wdata, reg_rdata, rv, cfg;
	logic               reg_wr, reg_rd, sleep_active;
	logic signed [15:0] pid_out;
	logic [31:0]        xs_state = 32'h0000A628; // seed 42536
	logic [31:0]        r;
	int                 bad_count, samples_checked, slp_m, p_exp;
	int                 th [4]; // sleep p, wake p, sleep f, wake f
	always #2 core_clk = ~core_clk;
	pls_core #(.TICK_MS(1)) uut (.core_clk(core_clk), .rstn(rstn),
		.ce(ce), .tick(tick), .run(run), .di_pol_toggle(di_pol_toggle),
		.di_gain_sel(di_gain_sel), .samples(samples), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pid_out(pid_out),
		.sleep_active(sleep_active));
	// compare and count
	task automatic chk(input string nm, input logic [15:0] got,
		input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one-cycle write; the spare edge keeps strobe updates apart
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		rv = reg_rdata;
	endtask
	// ticks six cycles apart, output settled three after each
	task automatic tk(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge core_clk);
			tick <= 1'b0;
			repeat (5) @(posedge core_clk);
		end
	endtask
	function automatic logic [31:0] xs();
		xs_state ^= xs_state << 13;
		xs_state ^= xs_state >> 17;
		xs_state ^= xs_state << 5;
		return xs_state;
	endfunction
	// sleep decision per tick; wake wins over sleep
	function automatic int slp_f(int cur);
		int p, q;
		bit sc, wc;
		p = cfg[3:0] == 2 ? samples.ain1 : samples.ain2;
		q = cfg[7:4] == 1 ? samples.ain1 : samples.ain2;
		sc = cfg[3:0] == 1 ? samples.out_freq < th[2] :
			(cfg[8] ? p < th[0] : p > th[0]);
		wc = cfg[7:4] == 0 ? samples.out_freq > th[3] : cfg[7:4] > 2 ? 0 :
			(cfg[8] ? q > th[1] : q < th[1]);
		if (cfg[3:0] == 0 || (cur && wc))
			return 0;
		return cur || (run && sc && !wc);
	endfunction
	task results();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		results();
	end
	initial begin
		{rstn, tick, run, di_pol_toggle, di_gain_sel} = 5'h0;
		ce = 1'b1;
		samples = '0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{bad_count, samples_checked, slp_m} = 0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < PLS_NREG; i++) begin
			rd(5'(i));
			chk("reset", rv, PLS_RST[i]);
		end
		rd(5'h15);
		chk("unmapped", rv, 16'h0000);
		wr(PLS_R_STAT, 16'hFFFF);
		rd(PLS_R_STAT);
		chk("status ro", rv, 16'h0000);
		// every setting and pin combination of polarity and gain select
		for (int i = 0; i < 16; i++) begin
			di_pol_toggle <= i[2];
			di_gain_sel <= i[3];
			wr(PLS_R_CTRL, 16'(i & 3));
			repeat (6) @(posedge core_clk);
			rd(PLS_R_STAT);
			chk("status", rv, {11'h0, i[1] & i[3], i[0] ^ i[2], 3'h0});
		end
		// set one without integral gives the proportional part; enabling the gain switch setting with the pin left high picks set two
		di_pol_toggle <= 1'b0;
		samples.setpoint <= 16'sd500;
		wr(PLS_R_CTRL, 16'h0004);
		wr(PLS_R_OUTTAU, 16'h0000);
		wr(PLS_R_KP2, 16'h0064);
		// proportional part alone with set one at its default gain
		p_exp = 500 * int'(PLS_RST[PLS_R_KP1]) / PLS_GAIN_DIV;
		wr(PLS_R_TI1, 16'h0000);
		wr(PLS_R_LOWER, 16'hFC18);
		run <= 1'b1;
		tk(3);
		chk("no integral", pid_out, 16'(p_exp));
		wr(PLS_R_CTRL, 16'h0006);
		tk(3);
		chk("set two", {15'h0, pid_out > p_exp}, 16'h1);
		wr(PLS_R_CTRL, 16'h0004);
		wr(PLS_R_TI1, 16'h0001);
		tk(3);
		chk("integral", {15'h0, pid_out > p_exp}, 16'h1);
		run <= 1'b0;
		wr(PLS_R_CTRL, 16'h0000);
		repeat (3) @(posedge core_clk);
		chk("stop", pid_out, 16'h0000);
		// negative polarity, computing while stopped
		wr(PLS_R_CTRL, 16'h0005);
		tk(3);
		chk("negative", {15'h0, pid_out < 0}, 16'h1);
		rd(PLS_R_STAT);
		chk("rws phase", {14'h0, rv[2:1]}, 16'h0002);
		run <= 1'b1;
		wr(PLS_R_CTRL, 16'h0004);
		foreach (th[k]) begin
			if (k < 2) begin
				cfg = k ? 16'h0064 : 16'hFF38;
				wr(PLS_R_UPPER, cfg);
				wr(PLS_R_LOWER, cfg);
				tk(2);
				chk("clamp", pid_out, cfg);
				rd(PLS_R_OUT);
				chk("out reg", rv, cfg);
			end
		end
		// output filter at ten ticks: one tick covers 1/11 of a step down
		wr(PLS_R_OUTTAU, 16'h000A);
		wr(PLS_R_UPPER, 16'hFF38);
		wr(PLS_R_LOWER, 16'hFF38);
		tk(1);
		chk("out filter", pid_out, 16'(100 - 300 / 11));
		// initial value held at start, cleared at stop
		run <= 1'b0;
		wr(PLS_R_CTRL, 16'h0000);
		wr(PLS_R_UPPER, 16'h03E8);
		wr(PLS_R_LOWER, 16'h0000);
		wr(PLS_R_HOLD, 16'h0001);
		wr(PLS_R_INIT, 16'h0123);
		run <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("hold", pid_out, 16'h0123);
		rd(PLS_R_STAT);
		chk("phase", {14'h0, rv[2:1]}, 16'h0001);
		run <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("stop", pid_out, 16'h0000);
		wr(PLS_R_CTRL, 16'h0004);
		run <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("no hold", pid_out, 16'h0000);
		// random sleep and wake settings and samples against the model
		for (int i = 0; i < 48; i++) begin
			r = xs();
			cfg = {7'h0, r[6], 2'h0, r[5:4], 2'h0, r[3:2]};
			wr(PLS_R_CTRL, {15'h0002, r[6]});
			for (int k = 0; k < 4; k++) begin
				th[k] = int'(xs() & 32'h3FF);
				wr(PLS_R_SLPP + 5'(k), 16'(th[k]));
			end
			samples.out_freq <= 16'(xs() & 32'h3FF);
			samples.ain1 <= 16'(xs() & 32'h3FF);
			samples.ain2 <= 16'(xs() & 32'h3FF);
			run <= r[7];
			wr(PLS_R_SLPCFG, cfg);
			tk(1);
			slp_m = slp_f(slp_m);
			chk("sleep", {15'h0, sleep_active}, 16'(slp_m));
		end
		results();
	end
endmodule
